// ===== common/vdi_pkg.sv
/*
  Constants, register layout and carrier types for the virtual deactivate block.
  Assumes a single 25 MHz clock and a plain same-clock register port.
*/
package vdi_pkg;

  // Register port
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register offsets
  localparam logic [7:0] OFF_IDENT = 8'h00;
  localparam logic [7:0] OFF_DEACT = 8'h04;
  localparam logic [7:0] OFF_VCTRL = 8'h08;
  localparam logic [7:0] OFF_HCTRL = 8'h0c;
  localparam logic [7:0] OFF_LR_BASE = 8'h10;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // List entries
  localparam int unsigned NUM_LR = 4;
  localparam int unsigned LR_IDX_W = 2;
  localparam logic [7:0] LR_SPAN = 8'h10;
  localparam int unsigned VCTRL_SPLIT_BIT = 0;

  // List entry states
  localparam logic [1:0] LR_INVALID = 2'h0;
  localparam logic [1:0] LR_PENDING = 2'h1;
  localparam logic [1:0] LR_ACTIVE = 2'h2;
  localparam logic [1:0] LR_ACT_PEND = 2'h3;

  // Identification layout
  typedef struct packed {
    logic [11:0] product_identifier;
    logic [3:0] arch_version;
    logic [3:0] revision;
    logic [11:0] implementer;
  } vdi_ident_t;

  // Identity values are arbitrary
  localparam vdi_ident_t IDENT_VALUE = '{
    product_identifier: 12'h0a5,
    arch_version: 4'h1,
    revision: 4'h0,
    implementer: 12'h5a5
  };

  // Deactivate write layout
  typedef struct packed {
    logic [18:0] rsvd;
    logic [2:0] source_processor_number;
    logic [9:0] interrupt_identifier;
  } vdi_deact_t;

  // List entry layout
  typedef struct packed {
    logic hardware_backed_flag;
    logic rsvd_hi;
    logic [1:0] state;
    logic [7:0] rsvd_lo;
    logic [9:0] physical_id;
    logic [9:0] virtual_id;
  } vdi_lr_t;

  // Hypervisor control layout
  typedef struct packed {
    logic [4:0] unmatched_completion_tally;
    logic [25:0] rsvd;
    logic maint_enable;
  } vdi_hctrl_t;

  // Request to the physical distributor
  typedef struct packed {
    logic [9:0] physical_id;
    logic [2:0] source_processor_number;
    logic nonsecure;
  } vdi_dist_req_t;

  localparam logic [4:0] TALLY_STEP = 5'h01;

endpackage : vdi_pkg

// ===== rtl/vdi_deactivate.sv
/*
  Virtual interface identification and deactivate logic with list entries.
  Assumes a same-clock register master and a distributor taking one-cycle requests.
*/
// What this block does
// - Identification word: product 31:20, version 19:16, revision 15:12, implementer 11:0.
// - Deactivate write: identifier bits 9:0, processor number 12:10, 31:13 reserved.
// - Matching active entry goes invalid; active-and-pending entry goes pending.
// - Unmatched identifier increments the tally, which can raise maintenance.
// - Hardware-backed match sends distributor deactivate with the entry's physical identifier.
// - Forwarded request is non-secure; distributor ignores it for Group 0.
// - Deactivation goes by identifier in any order, one register for both groups.
`timescale 1ns/100ps
module vdi_deactivate (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [vdi_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [vdi_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [vdi_pkg::DATA_W-1:0] reg_rdata,
  // Distributor request
  output logic dist_req_valid,
  output vdi_pkg::vdi_dist_req_t dist_req,
  // Maintenance level
  output logic maint_level
);

  // Address match on one word
  function automatic logic addr_is(input logic [vdi_pkg::ADDR_W-1:0] addr,
                                   input logic [vdi_pkg::ADDR_W-1:0] off);
    addr_is = (addr == off);
  endfunction : addr_is

  // List entry decode: {hit, index}
  function automatic logic [vdi_pkg::LR_IDX_W:0] lr_decode(
      input logic [vdi_pkg::ADDR_W-1:0] addr);
    logic [vdi_pkg::ADDR_W-1:0] rel;
    rel = addr - vdi_pkg::OFF_LR_BASE;
    lr_decode[vdi_pkg::LR_IDX_W] = (addr >= vdi_pkg::OFF_LR_BASE) &&
                                   (rel < vdi_pkg::LR_SPAN) &&
                                   (addr[1:0] == vdi_pkg::WORD_ALIGN);
    lr_decode[vdi_pkg::LR_IDX_W-1:0] = rel[vdi_pkg::LR_IDX_W+1:2];
  endfunction : lr_decode

  // Registers
  vdi_pkg::vdi_lr_t lr_ff [vdi_pkg::NUM_LR];
  vdi_pkg::vdi_lr_t nxt_lr [vdi_pkg::NUM_LR];
  logic split_ff;
  logic nxt_split;
  vdi_pkg::vdi_hctrl_t hctrl_ff;
  vdi_pkg::vdi_hctrl_t nxt_hctrl;
  logic [vdi_pkg::DATA_W-1:0] rdata_ff;
  logic [vdi_pkg::DATA_W-1:0] nxt_rdata;
  logic req_valid_ff;
  logic nxt_req_valid;
  vdi_pkg::vdi_dist_req_t req_ff;
  vdi_pkg::vdi_dist_req_t nxt_req;
  logic maint_ff;
  logic nxt_maint;

  // Decode and match
  vdi_pkg::vdi_deact_t deact_word;
  logic [vdi_pkg::LR_IDX_W:0] lr_dec;
  logic deact_wr;
  logic hit;
  logic [vdi_pkg::LR_IDX_W-1:0] hit_idx;

  assign deact_word = vdi_pkg::vdi_deact_t'(reg_wdata);
  assign lr_dec = lr_decode(reg_addr);
  // Deactivate taken only in split mode
  assign deact_wr = reg_wr && addr_is(reg_addr, vdi_pkg::OFF_DEACT) && split_ff;

  // Search every live entry by identifier, lowest index wins
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    for (int i = vdi_pkg::NUM_LR - 1; i >= 0; i--) begin
      if (lr_ff[i].state != vdi_pkg::LR_INVALID &&
          lr_ff[i].virtual_id == deact_word.interrupt_identifier) begin
        hit = 1'b1;
        hit_idx = vdi_pkg::LR_IDX_W'(i);
      end
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      if (addr_is(reg_addr, vdi_pkg::OFF_IDENT)) begin
        nxt_rdata = vdi_pkg::IDENT_VALUE;
      end else if (addr_is(reg_addr, vdi_pkg::OFF_VCTRL)) begin
        nxt_rdata[vdi_pkg::VCTRL_SPLIT_BIT] = split_ff;
      end else if (addr_is(reg_addr, vdi_pkg::OFF_HCTRL)) begin
        nxt_rdata = hctrl_ff;
      end else if (lr_dec[vdi_pkg::LR_IDX_W]) begin
        nxt_rdata = lr_ff[lr_dec[vdi_pkg::LR_IDX_W-1:0]];
      end
    end
  end

  // Register writes and deactivate effects
  always_comb begin
    nxt_lr = lr_ff;
    nxt_split = split_ff;
    nxt_hctrl = hctrl_ff;
    nxt_req_valid = 1'b0;
    nxt_req = req_ff;
    // Identification and deactivate words store nothing
    if (reg_wr && lr_dec[vdi_pkg::LR_IDX_W]) begin
      nxt_lr[lr_dec[vdi_pkg::LR_IDX_W-1:0]] = vdi_pkg::vdi_lr_t'(reg_wdata);
    end
    if (reg_wr && addr_is(reg_addr, vdi_pkg::OFF_VCTRL)) begin
      nxt_split = reg_wdata[vdi_pkg::VCTRL_SPLIT_BIT];
    end
    if (reg_wr && addr_is(reg_addr, vdi_pkg::OFF_HCTRL)) begin
      nxt_hctrl = vdi_pkg::vdi_hctrl_t'(reg_wdata);
    end
    if (deact_wr && hit) begin
      unique case (lr_ff[hit_idx].state)
        vdi_pkg::LR_ACTIVE: begin
          nxt_lr[hit_idx].state = vdi_pkg::LR_INVALID;
        end
        vdi_pkg::LR_ACT_PEND: begin
          nxt_lr[hit_idx].state = vdi_pkg::LR_PENDING;
        end
        default: begin
          // Pending-only entry left as it is
          nxt_lr[hit_idx].state = lr_ff[hit_idx].state;
        end
      endcase
      if (lr_ff[hit_idx].hardware_backed_flag) begin
        nxt_req_valid = 1'b1;
        nxt_req.physical_id = lr_ff[hit_idx].physical_id;
        nxt_req.source_processor_number = deact_word.source_processor_number;
        nxt_req.nonsecure = 1'b1;
      end
    end
    // Increment adds onto the tally of a same-cycle control write
    if (deact_wr && !hit) begin
      nxt_hctrl.unmatched_completion_tally =
        nxt_hctrl.unmatched_completion_tally + vdi_pkg::TALLY_STEP;
    end
    nxt_maint = nxt_hctrl.maint_enable &&
                (nxt_hctrl.unmatched_completion_tally != '0);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < vdi_pkg::NUM_LR; i++) begin
        lr_ff[i] <= '0;
      end
      split_ff <= 1'b0;
      hctrl_ff <= '0;
      rdata_ff <= '0;
      req_valid_ff <= 1'b0;
      req_ff <= '0;
      maint_ff <= 1'b0;
    end else begin
      lr_ff <= nxt_lr;
      split_ff <= nxt_split;
      hctrl_ff <= nxt_hctrl;
      rdata_ff <= nxt_rdata;
      req_valid_ff <= nxt_req_valid;
      req_ff <= nxt_req;
      maint_ff <= nxt_maint;
    end
  end

  assign reg_rdata = rdata_ff;
  assign dist_req_valid = req_valid_ff;
  assign dist_req = req_ff;
  assign maint_level = maint_ff;

  // Identification readback
  chk_ident_readback: assert property (
    @(posedge clk) disable iff (srst)
    reg_rd && addr_is(reg_addr, vdi_pkg::OFF_IDENT)
    |=> reg_rdata == vdi_pkg::IDENT_VALUE
  ) else $error("identification word wrong");

  // Write-only deactivate word reads as zero
  chk_deact_reads_zero: assert property (
    @(posedge clk) disable iff (srst)
    reg_rd && addr_is(reg_addr, vdi_pkg::OFF_DEACT)
    |=> reg_rdata == '0
  ) else $error("deactivate word not read as zero");

  // Tally moves exactly when no entry matched the identifier field
  chk_id_field_match: assert property (
    @(posedge clk) disable iff (srst)
    deact_wr
    |=> (hctrl_ff.unmatched_completion_tally !=
         $past(hctrl_ff.unmatched_completion_tally)) == !$past(hit)
  ) else $error("identifier match and tally disagree");

  // Active entry retires
  chk_active_retire: assert property (
    @(posedge clk) disable iff (srst)
    deact_wr && hit && lr_ff[hit_idx].state == vdi_pkg::LR_ACTIVE
    |=> lr_ff[$past(hit_idx)].state == vdi_pkg::LR_INVALID
  ) else $error("active entry not made invalid");

  // Active-and-pending falls back to pending
  chk_act_pend_drop: assert property (
    @(posedge clk) disable iff (srst)
    deact_wr && hit && lr_ff[hit_idx].state == vdi_pkg::LR_ACT_PEND
    |=> lr_ff[$past(hit_idx)].state == vdi_pkg::LR_PENDING
  ) else $error("active and pending entry not made pending");

  // Unmatched completion counted by one
  chk_tally_step: assert property (
    @(posedge clk) disable iff (srst)
    deact_wr && !hit
    |=> hctrl_ff.unmatched_completion_tally ==
        5'($past(hctrl_ff.unmatched_completion_tally) + vdi_pkg::TALLY_STEP)
  ) else $error("tally not incremented");

  // Hardware-backed entry forwards its physical identifier
  chk_hw_forward: assert property (
    @(posedge clk) disable iff (srst)
    deact_wr && hit && lr_ff[hit_idx].hardware_backed_flag
    |=> dist_req_valid && dist_req.physical_id == $past(lr_ff[hit_idx].physical_id)
        ##1 dist_req_valid == $past(deact_wr && hit && lr_ff[hit_idx].hardware_backed_flag)
  ) else $error("distributor deactivate missing or wrong");

  // No request without a hardware-backed match
  chk_no_spurious_req: assert property (
    @(posedge clk) disable iff (srst)
    dist_req_valid |-> $past(deact_wr && hit && lr_ff[hit_idx].hardware_backed_flag)
  ) else $error("spurious distributor request");

  // Forwarded request always non-secure
  chk_req_nonsecure: assert property (
    @(posedge clk) disable iff (srst)
    dist_req_valid |-> dist_req.nonsecure
  ) else $error("forwarded request not non-secure");

  // Split mode off: deactivate word has no effect
  chk_split_gate: assert property (
    @(posedge clk) disable iff (srst)
    reg_wr && addr_is(reg_addr, vdi_pkg::OFF_DEACT) && !split_ff
    |=> !dist_req_valid && $stable(hctrl_ff.unmatched_completion_tally)
  ) else $error("deactivate acted on with split mode off");

  // Read data stands only after a read strobe
  chk_rdata_idle: assert property (
    @(posedge clk) disable iff (srst)
    !reg_rd |=> reg_rdata == '0
  ) else $error("read data present without a read");

  // Maintenance level follows enable and a non-zero tally
  chk_maint_level: assert property (
    @(posedge clk) disable iff (srst)
    maint_level == (hctrl_ff.maint_enable && hctrl_ff.unmatched_completion_tally != '0)
  ) else $error("maintenance level wrong");

  // Forwarded request carries the written processor number
  chk_req_processor: assert property (
    @(posedge clk) disable iff (srst)
    deact_wr && hit && lr_ff[hit_idx].hardware_backed_flag
    |=> dist_req.source_processor_number == $past(deact_word.source_processor_number)
  ) else $error("forwarded processor number wrong");

  // Unmatched deactivate forwards nothing
  chk_unmatched_quiet: assert property (
    @(posedge clk) disable iff (srst)
    deact_wr && !hit |=> !dist_req_valid
  ) else $error("request sent for an unmatched identifier");

  // Selected entry is live and carries the written identifier
  chk_match_entry: assert property (
    @(posedge clk) disable iff (srst)
    deact_wr && hit
    |-> lr_ff[hit_idx].state != vdi_pkg::LR_INVALID &&
        lr_ff[hit_idx].virtual_id == deact_word.interrupt_identifier
  ) else $error("deactivate matched a wrong entry");

  // Request word holds between pulses
  chk_req_holds: assert property (
    @(posedge clk) disable iff (srst)
    !dist_req_valid |-> $stable(dist_req)
  ) else $error("request word changed without a pulse");

  // Deactivate word stores nothing into control state
  chk_deact_no_store: assert property (
    @(posedge clk) disable iff (srst)
    reg_wr && addr_is(reg_addr, vdi_pkg::OFF_DEACT)
    |=> $stable(split_ff) && $stable(hctrl_ff.maint_enable)
  ) else $error("deactivate write changed control state");

  // Entry word lands as written, physical identifier included
  chk_entry_store: assert property (
    @(posedge clk) disable iff (srst)
    reg_wr && lr_dec[vdi_pkg::LR_IDX_W]
    |=> lr_ff[$past(lr_dec[vdi_pkg::LR_IDX_W-1:0])] == $past(reg_wdata)
  ) else $error("entry write not stored");

endmodule : vdi_deactivate

// ===== sim/vdi_dist_model.sv
/*
  Behavioural physical distributor that takes forwarded deactivate requests.
  Assumes one-cycle request pulses on the block clock, no back-pressure.
*/
`timescale 1ns/100ps
module vdi_dist_model #(
  parameter logic [9:0] GROUP0_ID = 10'h3e0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Request from the virtual interface
  input wire logic dist_req_valid,
  input wire vdi_pkg::vdi_dist_req_t dist_req
);
  int n_taken_ff;
  logic take;
  // Non-secure requests only, Group 0 interrupts dropped
  assign take = dist_req_valid && dist_req.nonsecure && (dist_req.physical_id != GROUP0_ID);
  always_ff @(posedge clk) begin
    if (srst) begin
      n_taken_ff <= 0;
    end else if (take) begin
      n_taken_ff <= n_taken_ff + 1;
    end
  end
endmodule : vdi_dist_model

// ===== sim/testbench.sv
/*
  Self-checking bench for the virtual deactivate block.
  Assumes the distributor model beside it and a 25 MHz clock.
*/
`timescale 1ns/100ps
module testbench;
  logic clk;
  logic srst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic dist_req_valid;
  vdi_pkg::vdi_dist_req_t dist_req;
  logic maint_level;
  int n_mismatch;
  int samples_checked;

  vdi_deactivate vdi_deactivate_i (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dist_req_valid(dist_req_valid), .dist_req(dist_req), .maint_level(maint_level));
  vdi_dist_model vdi_dist_model_i (.clk(clk), .srst(srst),
    .dist_req_valid(dist_req_valid), .dist_req(dist_req));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic final_report();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read strobe one cycle, data taken in the cycle after
  task automatic chkrd(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(name, reg_rdata, exp);
  endtask : chkrd

  // Deactivate with reserved bits set, then look at the request pulse
  task automatic deact(input logic [2:0] cpu, input logic [9:0] id, input logic hw);
    wr(8'h04, {19'h7ffff, cpu, id});
    #1;
    check("request pulse", dist_req_valid, hw);
  endtask : deact

  function automatic logic [31:0] lr(input logic hw, input logic [1:0] st,
                                     input logic [9:0] pid, input logic [9:0] vid);
    return {hw, 1'b0, st, 8'h00, pid, vid};
  endfunction : lr

  initial begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    chkrd("ident", 8'h00, {12'h0a5, 4'h1, 4'h0, 12'h5a5});
    wr(8'h00, 32'h0);
    chkrd("ident after write", 8'h00, {12'h0a5, 4'h1, 4'h0, 12'h5a5});
    chkrd("deactivate read", 8'h04, 32'h0);
    chkrd("unmapped", 8'h40, 32'h0);
    wr(8'h10, lr(1'b1, 2'h2, 10'h123, 10'h011));
    wr(8'h14, lr(1'b0, 2'h3, 10'h000, 10'h022));
    wr(8'h18, lr(1'b1, 2'h2, 10'h3e0, 10'h033));
    wr(8'h0c, 32'h1);
    // Split mode off: write has no effect
    deact(3'h0, 10'h3ff, 1'b0);
    chkrd("tally split off", 8'h0c, 32'h1);
    wr(8'h08, 32'h1);
    // Later entry first, out of order
    deact(3'h0, 10'h022, 1'b0);
    chkrd("entry 1", 8'h14, lr(1'b0, 2'h1, 10'h000, 10'h022));
    deact(3'h5, 10'h011, 1'b1);
    check("request", dist_req, {10'h123, 3'h5, 1'b1});
    chkrd("entry 0", 8'h10, lr(1'b1, 2'h0, 10'h123, 10'h011));
    check("maint idle", maint_level, 1'b0);
    deact(3'h0, 10'h3ff, 1'b0);
    check("maint raised", maint_level, 1'b1);
    chkrd("tally", 8'h0c, {5'h01, 26'h0, 1'b1});
    deact(3'h2, 10'h033, 1'b1);
    check("request group 0", dist_req, {10'h3e0, 3'h2, 1'b1});
    @(posedge clk);
    #1;
    check("request pulse end", dist_req_valid, 1'b0);
    check("taken by model", vdi_dist_model_i.n_taken_ff, 32'h1);
    final_report();
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule : testbench
